// File: hdl/lin_slave_header_and_divider.sv
// Purpose: LIN mode control, fractional divider and header tracking behind Wishbone
// Assumes: the serial engine supplies RECEIVE_DATA_FULL_IN and consumes SAMPLE_TICK_OUT
// Notes: byte registers sit in data bits 7:0, upper bits read zero
// Contract
// - hardware clears update-method bit on receive-full
// - method 0: mantissa write loads divider
// - method 1: load divider at next character
// - enable and slave bits pick the mode
// - master send-break gives 13 low bits
// - slave detects break at 11 low bits
// - slave ignores send-break, header wakes receiver
// - slave maps divider onto baud/prescaler addresses
// - auto-synch enable drives synch measurement
// - detect method picks break or identifier
// - header interrupt when enabled and flagged
// - header flag cleared by status-then-control read
// - identifier method needs break, synch, identifier
// - synch state flag set, cleared, software abort
// - count falling edges during synch field
// - mantissa zero stops the serial clock
// - fraction low nibble, upper bits zero
// - fraction write first, mantissa write applies
// - header length visible only when enabled
// - header length loads FFh, 00h, measurement
// - length coded 57 minus bit count, quarters
// - sixteen oversample ticks per bit time
`timescale 1ns/10ps
`default_nettype none
module lin_slave_header_and_divider
  import lin_slave_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [31:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic RXD_IN,
  input wire logic RECEIVE_DATA_FULL_IN,
  output logic TXD_OUT,
  output logic SAMPLE_TICK_OUT,
  output logic MUTE_OUT,
  output logic IRQ_OUT
);

  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  ctrl3_t c3, next_c3;
  logic receiver_mute_bit, next_rwu;
  logic send_break_bit, next_sbk;
  logic [7:0] baud_reg, next_baud_reg;
  logic [7:0] etpr, next_etpr;
  logic [7:0] erpr, next_erpr;
  logic [3:0] frac_wr, next_frac_wr;
  logic [7:0] mant_pend, next_mant_pend;
  logic pend_wr, next_pend_wr;
  divider_t div, next_div;
  logic [7:0] header_length_value, next_lhl;
  logic lhe, next_lhe;
  logic armed, next_armed;
  hdr_state_t hstate, next_hstate;
  logic [1:0] char_cnt, next_char_cnt;
  logic [9:0] hdr_ticks, next_hdr_ticks;
  logic [7:0] low_cnt, next_low_cnt;
  logic [2:0] fall_cnt, next_fall_cnt;
  logic [15:0] meas, next_meas;
  logic meas_on, next_meas_on;
  logic receive_data_full_q, rx_q;
  logic irq, next_irq;
  logic [12:0] acc, next_acc;
  logic tick, next_tick;
  logic [7:0] brk_cnt, next_brk_cnt;
  logic txd, next_txd;

  logic req, wr, rd, mapped, slave, master, receive_data_full_rise, fall, break_hit;
  logic [7:0] idx, wd;
  logic [9:0] qsum;

  // bus decode and line events
  assign req = WB_CYC_IN & WB_STB_IN & ~ack;
  assign mapped = (WB_ADR_IN[31:10] == 22'h000000);
  assign idx = WB_ADR_IN[9:2];
  assign wd = WB_DAT_IN[7:0];
  assign wr = req & mapped & WB_WE_IN & WB_SEL_IN[0];
  assign rd = req & mapped & ~WB_WE_IN;
  // mode from enable and slave bits
  assign slave = c3.line_enable & c3.slave_select_bit;
  assign master = c3.line_enable & ~c3.slave_select_bit;
  assign receive_data_full_rise = RECEIVE_DATA_FULL_IN & ~receive_data_full_q;
  assign fall = rx_q & ~RXD_IN;
  assign break_hit = slave & tick & ~RXD_IN & (low_cnt == BREAK_DETECT_TICKS - 8'h01);
  assign qsum = hdr_ticks + 10'h002;

  // registers, divider control and header tracking
  always_comb begin
    next_ack = req;
    next_rdata = rdata;
    next_c3 = c3;
    next_rwu = receiver_mute_bit;
    next_sbk = send_break_bit;
    next_baud_reg = baud_reg;
    next_etpr = etpr;
    next_erpr = erpr;
    next_frac_wr = frac_wr;
    next_mant_pend = mant_pend;
    next_pend_wr = pend_wr;
    next_div = div;
    next_lhl = header_length_value;
    next_lhe = lhe;
    next_armed = armed;
    next_hstate = hstate;
    next_char_cnt = char_cnt;
    next_hdr_ticks = hdr_ticks;
    next_low_cnt = low_cnt;
    next_fall_cnt = fall_cnt;
    next_meas = meas;
    next_meas_on = meas_on;
    // read mux, latched with the request
    if (req) begin
      next_rdata = 32'h00000000;
    end
    if (rd) begin
      unique case (idx)
        IDX_STATUS: begin
          next_rdata[ST_RECEIVE_DATA_FULL_BIT] = RECEIVE_DATA_FULL_IN;
          next_rdata[ST_LHE_BIT] = lhe;
        end
        // divider at baud address in slave mode
        IDX_BAUD: next_rdata[7:0] = slave ? div.mantissa : baud_reg;
        IDX_CTRL2: next_rdata[7:0] = {6'h00, receiver_mute_bit, send_break_bit};
        IDX_CTRL3: next_rdata[7:0] = c3;
        IDX_ERPR: begin
          if (!slave) begin
            next_rdata[7:0] = erpr;
          end else if (c3.auto_synch_enable | c3.header_detect_method) begin
            next_rdata[7:0] = header_length_value;
          end
        end
        IDX_ETPR: next_rdata[7:0] = slave ? {4'h0, div.fraction} : etpr;
        default: next_rdata = 32'h00000000;
      endcase
    end
    // status access arms, control three read clears
    if (req & mapped & (idx == IDX_STATUS)) begin
      next_armed = 1'b1;
    end else if (rd & (idx == IDX_CTRL3) & armed) begin
      next_armed = 1'b0;
      next_c3.header_detected_flag = 1'b0;
      next_lhe = 1'b0;
    end
    // register writes
    if (wr) begin
      unique case (idx)
        IDX_BAUD: begin
          if (!slave) begin
            next_baud_reg = wd;
          end else if (c3.divider_update_method) begin
            next_mant_pend = wd;
            next_pend_wr = 1'b1;
          end else begin
            next_div = {wd, frac_wr};
          end
        end
        IDX_ETPR: begin
          if (slave) begin
            next_frac_wr = wd[3:0];
          end else begin
            next_etpr = wd;
          end
        end
        IDX_ERPR: begin
          if (!slave) begin
            next_erpr = wd;
          end
        end
        IDX_CTRL2: begin
          next_sbk = wd[C2_SBK_BIT];
          if (!(slave & RECEIVE_DATA_FULL_IN)) begin
            next_rwu = wd[C2_RWU_BIT];
          end
        end
        IDX_CTRL3: begin
          next_c3.divider_update_method = wd[7];
          next_c3.line_enable = wd[6];
          next_c3.slave_select_bit = wd[5];
          next_c3.auto_synch_enable = wd[4];
          next_c3.header_detect_method = wd[3];
          next_c3.header_interrupt_enable = wd[2];
          if (wd[7] & ~c3.divider_update_method) begin
            next_pend_wr = 1'b0;
          end
          if (!wd[C3_LSF_BIT]) begin
            next_c3.synch_field_state = 1'b0;
            next_hstate = HDR_IDLE;
          end
        end
        default: next_pend_wr = pend_wr;
      endcase
    end
    // deferred load on a received character
    if (receive_data_full_rise & slave & c3.divider_update_method) begin
      next_div = pend_wr ? {mant_pend, frac_wr} : div;
      next_pend_wr = 1'b0;
    end
    if (RECEIVE_DATA_FULL_IN) begin
      next_c3.divider_update_method = 1'b0;
    end
    // low run length for break detection
    if (tick) begin
      if (RXD_IN) begin
        next_low_cnt = 8'h00;
      end else if (low_cnt != BREAK_DETECT_TICKS) begin
        next_low_cnt = low_cnt + 8'h01;
      end
    end
    if (tick & (hstate != HDR_IDLE)) begin
      next_hdr_ticks = hdr_ticks + 10'h001;
    end
    if (meas_on) begin
      next_meas = meas + 16'h0001;
    end
    unique case (hstate)
      HDR_IDLE: next_meas_on = 1'b0;
      HDR_SYNCH: begin
        if (receive_data_full_rise) begin
          next_char_cnt = char_cnt + 2'h1;
        end
        if (c3.auto_synch_enable) begin
          // measure between first and fifth falling edge
          if (fall) begin
            next_fall_cnt = fall_cnt + 3'h1;
            if (fall_cnt == 3'h0) begin
              next_meas_on = 1'b1;
              // the first clock of the span counts as one
              next_meas = 16'h0001;
            end
            if (fall_cnt == SYNCH_FALL_EDGES - 3'h1) begin
              // eight bit times give sixteenths of the divider
              next_div = meas[15] ? 12'hfff : meas[14:3];
              next_meas_on = 1'b0;
              next_c3.synch_field_state = 1'b0;
              next_hstate = HDR_IDENT;
            end
          end
        end else if (receive_data_full_rise) begin
          next_c3.synch_field_state = 1'b0;
          next_hstate = HDR_IDENT;
        end
      end
      HDR_IDENT: begin
        if (receive_data_full_rise) begin
          if (char_cnt == 2'h0) begin
            next_char_cnt = 2'h1;
          end else begin
            // measured length on a full header
            next_lhl = HEADER_QUARTERS - qsum[9:2];
            next_hstate = HDR_IDLE;
            if (c3.header_detect_method) begin
              next_c3.header_detected_flag = 1'b1;
              next_rwu = 1'b0;
            end
          end
        end
      end
      default: next_hstate = HDR_IDLE;
    endcase
    if ((hstate != HDR_IDLE) & (hdr_ticks >= HEADER_TIMEOUT_TICKS)) begin
      next_lhl = LHL_TIMEOUT;
      next_lhe = 1'b1;
      next_c3.synch_field_state = 1'b0;
      next_meas_on = 1'b0;
      next_hstate = HDR_IDLE;
    end
    // break sets synch state, wins over clears
    if (break_hit) begin
      next_c3.synch_field_state = 1'b1;
      next_lhl = LHL_BREAK;
      next_hstate = HDR_SYNCH;
      next_hdr_ticks = {2'b00, BREAK_DETECT_TICKS};
      next_char_cnt = 2'h0;
      next_fall_cnt = 3'h0;
      next_meas_on = 1'b0;
      // break method flags header at the break
      if (!c3.header_detect_method) begin
        next_c3.header_detected_flag = 1'b1;
        next_rwu = 1'b0;
      end
    end
    // header logic idles outside slave mode
    if (!slave) begin
      next_c3.synch_field_state = 1'b0;
      next_hstate = HDR_IDLE;
      next_meas_on = 1'b0;
    end
    next_irq = slave & c3.header_interrupt_enable & c3.header_detected_flag;
  end

  // register stage for the control group
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
      c3 <= ctrl3_t'(RST_REG8);
      receiver_mute_bit <= 1'b0;
      send_break_bit <= 1'b0;
      baud_reg <= RST_REG8;
      etpr <= RST_REG8;
      erpr <= RST_REG8;
      frac_wr <= RST_FRAC;
      mant_pend <= RST_REG8;
      pend_wr <= 1'b0;
      div <= {RST_REG8, RST_FRAC};
      header_length_value <= RST_REG8;
      lhe <= 1'b0;
      armed <= 1'b0;
      hstate <= HDR_IDLE;
      char_cnt <= 2'h0;
      hdr_ticks <= 10'h000;
      low_cnt <= 8'h00;
      fall_cnt <= 3'h0;
      meas <= 16'h0000;
      meas_on <= 1'b0;
      receive_data_full_q <= 1'b0;
      rx_q <= 1'b1;
      irq <= 1'b0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      c3 <= next_c3;
      receiver_mute_bit <= next_rwu;
      send_break_bit <= next_sbk;
      baud_reg <= next_baud_reg;
      etpr <= next_etpr;
      erpr <= next_erpr;
      frac_wr <= next_frac_wr;
      mant_pend <= next_mant_pend;
      pend_wr <= next_pend_wr;
      div <= next_div;
      header_length_value <= next_lhl;
      lhe <= next_lhe;
      armed <= next_armed;
      hstate <= next_hstate;
      char_cnt <= next_char_cnt;
      hdr_ticks <= next_hdr_ticks;
      low_cnt <= next_low_cnt;
      fall_cnt <= next_fall_cnt;
      meas <= next_meas;
      meas_on <= next_meas_on;
      receive_data_full_q <= RECEIVE_DATA_FULL_IN;
      rx_q <= RXD_IN;
      irq <= next_irq;
    end
  end

  // oversample tick generator and break transmitter
  always_comb begin
    next_acc = acc;
    next_tick = 1'b0;
    next_brk_cnt = brk_cnt;
    next_txd = txd;
    if (div.mantissa == 8'h00) begin
      next_acc = 13'h0000;
    end else if (acc >= {1'b0, div}) begin
      // a divider made smaller restarts the phase, no burst of ticks
      next_acc = 13'h0000;
    end else begin
      // one tick per divider value of clocks
      next_acc = acc + ACC_STEP;
      if (next_acc >= {1'b0, div}) begin
        next_tick = 1'b1;
        next_acc = next_acc - {1'b0, div};
      end
    end
    if (!txd) begin
      if (tick) begin
        next_brk_cnt = brk_cnt + 8'h01;
        if (brk_cnt == BREAK_SEND_TICKS - 8'h01) begin
          next_txd = 1'b1;
          next_brk_cnt = 8'h00;
        end
      end
    end else if (master & send_break_bit) begin
      next_txd = 1'b0;
      next_brk_cnt = 8'h00;
    end
  end

  // register stage for the tick group
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      acc <= 13'h0000;
      tick <= 1'b0;
      brk_cnt <= 8'h00;
      txd <= 1'b1;
    end else begin
      acc <= next_acc;
      tick <= next_tick;
      brk_cnt <= next_brk_cnt;
      txd <= next_txd;
    end
  end

  // outputs straight from flops
  assign WB_ACK_OUT = ack;
  assign WB_DAT_OUT = rdata;
  assign TXD_OUT = txd;
  assign SAMPLE_TICK_OUT = tick;
  assign MUTE_OUT = receiver_mute_bit;
  assign IRQ_OUT = irq;

endmodule // lin_slave_header_and_divider
`default_nettype wire

// File: hdl/lin_slave_pkg.sv
// Purpose: shared constants and types for the LIN slave header and divider block
// Assumes: 8-bit registers, one per 32-bit Wishbone word at byte address 4*index
// Notes: register indices are kept as printed; counts are in oversample ticks
package lin_slave_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h40;
  localparam logic [7:0] IDX_BAUD = 8'h42;
  localparam logic [7:0] IDX_CTRL2 = 8'h44;
  localparam logic [7:0] IDX_CTRL3 = 8'h45;
  localparam logic [7:0] IDX_ERPR = 8'h46;
  localparam logic [7:0] IDX_ETPR = 8'h47;

  // status, control two and control three bit positions
  localparam int unsigned ST_RECEIVE_DATA_FULL_BIT = 5;
  localparam int unsigned ST_LHE_BIT = 3;
  localparam int unsigned C2_RWU_BIT = 1;
  localparam int unsigned C2_SBK_BIT = 0;
  localparam int unsigned C3_LSF_BIT = 0;

  // reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [3:0] RST_FRAC = 4'h0;

  // timing counts
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [7:0] BREAK_DETECT_TICKS = 8'(11 * OVERSAMPLE);
  localparam logic [7:0] BREAK_SEND_TICKS = 8'(13 * OVERSAMPLE);
  localparam logic [9:0] HEADER_TIMEOUT_TICKS = 10'(57 * OVERSAMPLE);
  localparam logic [7:0] HEADER_QUARTERS = 8'(57 * 4);
  localparam logic [2:0] SYNCH_FALL_EDGES = 3'h5;
  localparam logic [12:0] ACC_STEP = 13'(OVERSAMPLE);

  // header length special values
  localparam logic [7:0] LHL_BREAK = 8'hff;
  localparam logic [7:0] LHL_TIMEOUT = 8'h00;

  // control register three layout
  typedef struct packed {
    logic divider_update_method;
    logic line_enable;
    logic slave_select_bit;
    logic auto_synch_enable;
    logic header_detect_method;
    logic header_interrupt_enable;
    logic header_detected_flag;
    logic synch_field_state;
  } ctrl3_t;

  // fractional divider in sixteenths
  typedef struct packed {
    logic [7:0] mantissa;
    logic [3:0] fraction;
  } divider_t;

  // header tracking states
  typedef enum logic [2:0] {
    HDR_IDLE = 3'b001,
    HDR_SYNCH = 3'b010,
    HDR_IDENT = 3'b100
  } hdr_state_t;

endpackage

// File: tb/lin_slave_assertions.sv
// Purpose: port checks for the LIN slave header and divider block
// Assumes: one clock, asynchronous active-low reset
// Notes: mode bits mirrored from software writes to control three
`timescale 1ns/10ps
`default_nettype none
module lin_slave_assertions
  import lin_slave_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [31:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic RXD_IN,
  input wire logic RECEIVE_DATA_FULL_IN,
  input wire logic TXD_OUT,
  input wire logic SAMPLE_TICK_OUT,
  input wire logic MUTE_OUT,
  input wire logic IRQ_OUT
);
  logic [7:0] mode;
  logic [8:0] lows;
  logic take;
  logic rd;
  assign take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign rd = WB_ACK_OUT && !WB_WE_IN;
  // mode mirror and ticks counted while the transmit line is low
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mode <= 8'h00;
      lows <= 9'h000;
    end else begin
      if (take && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == {22'h0, IDX_CTRL3, 2'b00}) begin
        mode <= WB_DAT_IN[7:0];
      end
      lows <= TXD_OUT ? 9'h000 : lows + 9'(SAMPLE_TICK_OUT);
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence s_take;
    take;
  endsequence
  sequence s_ack;
    WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence
  a_ack_timing: assert property (s_take |=> s_ack)
    else $error("ack timing");
  a_upper_zero: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0)
    else $error("upper data bits set");
  a_unmapped_zero: assert property (rd && WB_ADR_IN[31:10] != 22'h0 |-> WB_DAT_OUT == 32'h0)
    else $error("unmapped read not zero");
  a_frac_upper: assert property (rd && WB_ADR_IN[9:2] == IDX_ETPR |-> WB_DAT_OUT[7:4] == 4'h0)
    else $error("fraction upper bits set");
  a_length_hidden: assert property (rd && WB_ADR_IN[9:2] == IDX_ERPR
    && !(mode[6] && mode[5] && (mode[4] || mode[3])) |-> WB_DAT_OUT[7:0] == 8'h00)
    else $error("header length visible");
  a_break_master: assert property ($fell(TXD_OUT) |-> mode[6] && !mode[5])
    else $error("break outside master mode");
  a_break_length: assert property ($rose(TXD_OUT) |-> lows == {1'b0, BREAK_SEND_TICKS})
    else $error("break length");
  a_mute_cause: assert property ($rose(MUTE_OUT) |-> $past(take && WB_WE_IN
    && WB_ADR_IN[9:2] == IDX_CTRL2 && WB_DAT_IN[C2_RWU_BIT]))
    else $error("mute set without write");
  a_irq_enable: assert property ($rose(IRQ_OUT) |-> $past(mode[2]))
    else $error("irq while disabled");
  a_irq_clear: assert property ($fell(IRQ_OUT) |-> $past(take && WB_ADR_IN[9:2] == IDX_CTRL3, 2))
    else $error("irq fell without control access");
endmodule // lin_slave_assertions
bind lin_slave_header_and_divider lin_slave_assertions u_chk (.CLK_IN(CLK_IN),
  .RSTN_IN(RSTN_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN),
  .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
  .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .RXD_IN(RXD_IN), .RECEIVE_DATA_FULL_IN(RECEIVE_DATA_FULL_IN),
  .TXD_OUT(TXD_OUT), .SAMPLE_TICK_OUT(SAMPLE_TICK_OUT), .MUTE_OUT(MUTE_OUT),
  .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// File: tb/lin_node_model.sv
// Purpose: other LIN node driving the receive line and receive-full
// Assumes: called just after a rising clock edge
// Notes: recessive idle is high, as the bus pull-up gives
`timescale 1ns/10ps
`default_nettype none
module lin_node_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_in,
  output logic rxd_out,
  output logic receive_data_full_out
);
  // idle bus, nothing received
  initial begin
    rxd_out = 1'b1;
    receive_data_full_out = 1'b0;
  end
  // hold one level for whole bit times
  task automatic hold_bits(input logic level, input int bits);
    rxd_out <= level;
    repeat (bits * BIT_CLKS) @(posedge clk_in);
  endtask
  // delimiter bit leads straight into the next field
  task automatic send_break(input int bits);
    hold_bits(1'b0, bits);
    hold_bits(1'b1, 1);
  endtask
  // one cycle of receive-full after a character
  task automatic pulse_receive_data_full();
    receive_data_full_out <= 1'b1;
    @(posedge clk_in);
    receive_data_full_out <= 1'b0;
  endtask
  // start bit, lsb first, stop bit, then receive-full
  task automatic send_char(input logic [7:0] b);
    hold_bits(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold_bits(b[i], 1);
    end
    hold_bits(1'b1, 1);
    pulse_receive_data_full();
  endtask
endmodule // lin_node_model
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench for the LIN slave header and divider
// Assumes: divider 1.0 gives one tick per clock, 16 clocks a bit
// Notes: reads note expected bytes, the monitor compares on ack
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); \
    end \
  end
module tb_top
  import lin_slave_pkg::*;
  ;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic ack, rxd, receive_data_full, txd, tick, mute, irq;
  logic [7:0] e_m;
  logic [31:0] seed = 32'h25b684cd;
  logic [7:0] exp_q[$];
  int errors = 0;
  int total_checks = 0;
  lin_slave_header_and_divider DUT (.CLK_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dw),
    .WB_DAT_OUT(dr), .WB_ACK_OUT(ack), .RXD_IN(rxd), .RECEIVE_DATA_FULL_IN(receive_data_full), .TXD_OUT(txd),
    .SAMPLE_TICK_OUT(tick), .MUTE_OUT(mute), .IRQ_OUT(irq));
  lin_node_model #(.BIT_CLKS(16)) node (.clk_in(clk), .rxd_out(rxd), .receive_data_full_out(receive_data_full));
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
    input logic [7:0] e);
    int n;
    if (!w) exp_q.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dw <= {24'h0, d};
    n = 0;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      errors++;
      final_report();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    wb(1'b1, {22'h0, i, 2'b00}, d, 8'h00);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    wb(1'b0, {22'h0, i, 2'b00}, 8'h00, e);
  endtask
  // count cycles of tick, or of a low transmit line
  task automatic count_hi(input logic pick, output int c);
    c = 0;
    repeat (300) begin
      @(posedge clk);
      if ((pick ? tick : ~txd) === 1'b1) c++;
    end
  endtask
  // wait for a break, then count its low cycles
  task automatic break_len(output int lows);
    int n;
    lows = 0;
    n = 0;
    while (txd !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    while (txd === 1'b0 && lows < 400) begin
      @(posedge clk);
      lows++;
    end
  endtask
  // compare each read answer with the oldest noted value
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e_m = (exp_q.size() > 0) ? exp_q.pop_front() : ~dr[7:0];
      `CHK(dr[7:0], e_m)
    end
  end
  initial begin
    int c;
    logic [7:0] m;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(IDX_CTRL3, RST_REG8);
    rd(IDX_BAUD, RST_REG8);
    rd(IDX_ERPR, RST_REG8);
    wb(1'b0, 32'h0000_0400, 8'h00, 8'h00);
    count_hi(1'b1, c);
    `CHK(c, 0)
    // fraction is held until the mantissa write
    wr(IDX_CTRL3, 8'h60);
    wr(IDX_ETPR, 8'hf5);
    rd(IDX_ETPR, 8'h00);
    wr(IDX_BAUD, 8'h01);
    rd(IDX_ETPR, 8'h05);
    rd(IDX_BAUD, 8'h01);
    wr(IDX_ETPR, 8'h00);
    wr(IDX_BAUD, 8'h01);
    // break in master mode, none in slave mode
    wr(IDX_CTRL3, 8'h40);
    fork
      break_len(c);
      begin
        wr(IDX_CTRL2, 8'h01);
        wr(IDX_CTRL2, 8'h00);
      end
    join
    `CHK(c, 208)
    wr(IDX_CTRL3, 8'h60);
    wr(IDX_CTRL2, 8'h01);
    count_hi(1'b0, c);
    `CHK(c, 0)
    // break method with mute and interrupt, then timeout
    wr(IDX_CTRL2, 8'h02);
    wr(IDX_CTRL3, 8'h64);
    node.send_break(10);
    rd(IDX_CTRL3, 8'h64);
    node.send_break(13);
    rd(IDX_CTRL3, 8'h67);
    `CHK(mute, 1'b0)
    `CHK(irq, 1'b1)
    repeat (720) @(posedge clk);
    rd(IDX_STATUS, 8'h08);
    rd(IDX_CTRL3, 8'h66);
    rd(IDX_CTRL3, 8'h64);
    `CHK(irq, 1'b0)
    // identifier method, full header with random identifier
    seed = lfsr(seed);
    wr(IDX_CTRL3, 8'h68);
    node.send_break(13);
    fork
      node.send_char(8'h55);
      begin
        rd(IDX_ERPR, LHL_BREAK);
        rd(IDX_CTRL3, 8'h69);
      end
    join
    node.send_char(seed[7:0]);
    rd(IDX_ERPR, 8'h5c);
    rd(IDX_STATUS, 8'h00);
    rd(IDX_CTRL3, 8'h6a);
    // deferred divider update on the next character
    seed = lfsr(seed);
    m = seed[7:0] | 8'h80;
    wr(IDX_CTRL3, 8'he8);
    wr(IDX_BAUD, m);
    rd(IDX_BAUD, 8'h01);
    node.pulse_receive_data_full();
    rd(IDX_BAUD, m);
    rd(IDX_CTRL3, 8'h68);
    wr(IDX_BAUD, 8'h01);
    rd(IDX_BAUD, 8'h01);
    wr(IDX_CTRL3, 8'he8);
    node.pulse_receive_data_full();
    rd(IDX_BAUD, 8'h01);
    rd(IDX_ERPR, 8'h5c);
    // auto synch from a 1.5 divider, length shown by auto synch alone
    wr(IDX_CTRL3, 8'h70);
    wr(IDX_ETPR, 8'h08);
    wr(IDX_BAUD, 8'h01);
    count_hi(1'b1, c);
    `CHK(c, 200)
    node.send_break(20);
    rd(IDX_ERPR, LHL_BREAK);
    rd(IDX_CTRL3, 8'h73);
    node.send_char(8'h55);
    rd(IDX_ETPR, 8'h00);
    rd(IDX_BAUD, 8'h01);
    rd(IDX_CTRL3, 8'h72);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
